// file: rtl/csc_flags_pkg.sv
/*
 * constants for the card status-change flag block: register offsets,
 * field positions, reset values and pin slot numbers.
 * assumes a byte-addressed apb slave with 32-bit data, one word per register.
 */
`default_nettype none

package csc_flags_pkg;

   // ----------------------------------------------------------------
   // bus geometry and register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 12;
   localparam int          DATA_W         = 32;
   localparam logic [11:0] STATUS_OFFSET  = 12'h804;
   localparam logic [11:0] CONTROL_OFFSET = 12'h808;
   localparam logic [11:0] ENABLE_OFFSET  = 12'h80c;
   localparam logic [11:0] PIN_OFFSET     = 12'h810;

   // ----------------------------------------------------------------
   // flag and enable bit positions
   // ----------------------------------------------------------------
   localparam int FLAG_W        = 4;
   localparam int CD_CHANGE_BIT = 3;
   localparam int READY_BIT     = 2;
   localparam int BATT_LOW_BIT  = 1;
   localparam int BATT_DEAD_BIT = 0;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int         PME_ENABLE_BIT  = 0;
   localparam int         CLEAR_MODE_BIT  = 2;
   localparam int         CARD_KIND_BIT   = 5;
   localparam int         RING_ENABLE_BIT = 7;
   localparam logic [7:0] CONTROL_MASK    = 8'ha5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]        STATUS_RESET  = 8'h00;
   localparam logic [7:0]        CONTROL_RESET = 8'h00;
   localparam logic [FLAG_W-1:0] ENABLE_RESET  = 4'h0;

   // ----------------------------------------------------------------
   // synchronised pin slots
   // ----------------------------------------------------------------
   localparam int         PIN_W          = 7;
   localparam int         PIN_CD_FIRST   = 0;
   localparam int         PIN_CD_SECOND  = 1;
   localparam int         PIN_READY      = 2;
   localparam int         PIN_BVD_RING   = 3;
   localparam int         PIN_BATT_WARN  = 4;
   localparam int         PIN_STS_CHANGE = 5;
   localparam int         PIN_BUS_RESET  = 6;
   // idle levels: active-low pins rest high
   localparam logic [6:0] PIN_IDLE       = 7'h7b;

endpackage

`default_nettype wire

// file: rtl/pin_sync.sv
/*
 * two-stage synchroniser for a vector of slow asynchronous pins.
 * assumes each bit is a level that stays put for several clock periods.
 */
`default_nettype none

module pin_sync #(
   parameter int             WIDTH      = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_b_i,
   // pins in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_type;

   sync_state_type state;
   sync_state_type next_state;

   // the first stage feeds the second and nothing else
   always_comb begin
      next_state.first  = async_i;
      next_state.second = state.first;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         state <= {RESET_VALUE, RESET_VALUE};
      end else begin
         state <= next_state;
      end
   end

   assign sync_o = state.second;

endmodule

`default_nettype wire

// file: rtl/card_status_change_flags.sv
/*
 * sticky card status-change flags for one 16-bit card socket, with their
 * source enables and the control bits that steer them, behind an apb slave.
 * assumes the card pins are asynchronous levels and the host bus reset
 * arrives as an asynchronous active-low level; RST_B_I is the global reset.
 */
`default_nettype none

module card_status_change_flags
   import csc_flags_pkg::*;
(
   // clock and global reset
   input  wire logic              CLOCK_I,
   input  wire logic              RST_B_I,
   // host bus reset, asynchronous
   input  wire logic              HOST_BUS_RESET_B_I,
   // apb slave
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [DATA_W-1:0] PWDATA_I,
   input  wire logic [3:0]        PSTRB_I,
   output logic      [DATA_W-1:0] PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   // card socket pins, asynchronous
   input  wire logic              CARD_DETECT_FIRST_B_I,
   input  wire logic              CARD_DETECT_SECOND_B_I,
   input  wire logic              CARD_READY_I,
   input  wire logic              BATTERY_VOLTAGE_DETECT_PIN_I,
   input  wire logic              BATTERY_WARNING_PIN_B_I,
   input  wire logic              CARD_STATUS_CHANGE_PIN_B_I,
   // interrupt request toward the host
   output logic                   CSC_IRQ_O
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [FLAG_W-1:0] flag;
      logic [FLAG_W-1:0] enable;
      logic [7:0]        control;
      logic              cd_first_last;
      logic              cd_second_last;
      logic              ready_last;
      logic              read_status;
      logic [DATA_W-1:0] prdata;
      logic              irq;
   } state_type;

   state_type state;
   state_type next_state;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [11:0]       offset);
      hit = (addr == offset);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pins_async;
   logic [PIN_W-1:0] pins;

   assign pins_async = {HOST_BUS_RESET_B_I,
                        CARD_STATUS_CHANGE_PIN_B_I,
                        BATTERY_WARNING_PIN_B_I,
                        BATTERY_VOLTAGE_DETECT_PIN_I,
                        CARD_READY_I,
                        CARD_DETECT_SECOND_B_I,
                        CARD_DETECT_FIRST_B_I};

   pin_sync #(
      .WIDTH       (PIN_W),
      .RESET_VALUE (PIN_IDLE)
   ) u_pin_sync (
      .clock_i (CLOCK_I),
      .rst_b_i (RST_B_I),
      .async_i (pins_async),
      .sync_o  (pins)
   );

   // ----------------------------------------------------------------
   // decoded levels
   // ----------------------------------------------------------------
   logic card_detect_first;
   logic card_detect_second;
   logic card_ready;
   logic ring_indicate_pin;
   logic battery_low;
   logic status_change_asserted;
   logic host_bus_reset;

   assign card_detect_first      = pins[PIN_CD_FIRST];
   assign card_detect_second     = pins[PIN_CD_SECOND];
   assign card_ready             = pins[PIN_READY];
   // the battery voltage pin doubles as ring indicate, active low
   assign ring_indicate_pin      = !pins[PIN_BVD_RING];
   assign battery_low            = !pins[PIN_BATT_WARN];
   assign status_change_asserted = !pins[PIN_STS_CHANGE];
   assign host_bus_reset         = !pins[PIN_BUS_RESET];

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   logic power_mgmt_event;
   logic write_one_clear;
   logic io_card;
   logic ring_indicate_enable;

   assign power_mgmt_event     = state.control[PME_ENABLE_BIT];
   assign write_one_clear      = state.control[CLEAR_MODE_BIT];
   assign io_card              = state.control[CARD_KIND_BIT];
   assign ring_indicate_enable = state.control[RING_ENABLE_BIT];

   // ----------------------------------------------------------------
   // bus phases
   // ----------------------------------------------------------------
   logic setup_phase;
   logic access_phase;
   logic hit_status;
   logic hit_control;
   logic hit_enable;
   logic hit_pin;
   logic hit_any;
   logic low_lane;

   assign setup_phase  = PSEL_I && !PENABLE_I;
   assign access_phase = PSEL_I && PENABLE_I;
   assign hit_status   = hit(PADDR_I, STATUS_OFFSET);
   assign hit_control  = hit(PADDR_I, CONTROL_OFFSET);
   assign hit_enable   = hit(PADDR_I, ENABLE_OFFSET);
   assign hit_pin      = hit(PADDR_I, PIN_OFFSET);
   assign hit_any      = hit_status || hit_control || hit_enable || hit_pin;
   assign low_lane     = PSTRB_I[0];

   // every access finishes in its first access cycle
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = access_phase && !hit_any;
   assign PRDATA_O  = state.prdata;
   assign CSC_IRQ_O = state.irq;

   // ----------------------------------------------------------------
   // flag view as software sees it
   // ----------------------------------------------------------------
   function automatic logic [FLAG_W-1:0] visible(
      input logic [FLAG_W-1:0] flag,
      input logic [FLAG_W-1:0] enable,
      input logic              io_kind,
      input logic              ring_mode,
      input logic              ring_level);
      logic [FLAG_W-1:0] view;
      view = flag & enable;
      if (io_kind) begin
         view[READY_BIT]    = 1'b0;
         view[BATT_LOW_BIT] = 1'b0;
      end
      if (ring_mode) begin
         view[BATT_DEAD_BIT] = enable[BATT_DEAD_BIT] && ring_level;
      end
      visible = view;
   endfunction

   logic [FLAG_W-1:0] view_now;

   assign view_now = visible(state.flag, state.enable, io_card,
                             ring_indicate_enable, ring_indicate_pin);

   // ----------------------------------------------------------------
   // pin events
   // ----------------------------------------------------------------
   logic cd_toggled;
   logic ready_rose;
   logic battery_low_event;
   logic battery_dead_event;

   // a toggle seen while its source is disabled is dropped, not held
   // back, so power-up levels cannot raise a stale change
   assign cd_toggled         = (card_detect_first != state.cd_first_last) ||
                               (card_detect_second != state.cd_second_last);
   assign ready_rose         = card_ready && !state.ready_last;
   // battery low and status change are levels: while a pin stays
   // asserted its flag is set again every cycle, even right after a clear
   assign battery_low_event  = battery_low;
   assign battery_dead_event = status_change_asserted;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic [FLAG_W-1:0] set_flag;
   logic [FLAG_W-1:0] clear_flag;
   logic [FLAG_W-1:0] view_next;
   logic              context_reset;

   always_comb begin
      next_state = state;

      // edge trackers always follow the pins
      next_state.cd_first_last  = card_detect_first;
      next_state.cd_second_last = card_detect_second;
      next_state.ready_last     = card_ready;

      // events, each gated by its own source enable
      set_flag = '0;
      set_flag[CD_CHANGE_BIT] = cd_toggled;
      set_flag[READY_BIT]     = !io_card && ready_rose;
      set_flag[BATT_LOW_BIT]  = !io_card && battery_low_event;
      // in ring mode bit 0 is a live view, so nothing is latched
      set_flag[BATT_DEAD_BIT] =
         !ring_indicate_enable && battery_dead_event;
      set_flag = set_flag & state.enable;

      // clears: in read-clear mode only bits that the read really returned are cleared,
      // so an event landing between setup and access is kept
      clear_flag = '0;
      if (access_phase && state.read_status && !write_one_clear) begin
         clear_flag = state.prdata[FLAG_W-1:0];
      end
      if (access_phase && PWRITE_I && hit_status && write_one_clear
          && low_lane) begin
         clear_flag = PWDATA_I[FLAG_W-1:0];
      end

      // set beats a coincident clear
      next_state.flag = (state.flag & ~clear_flag) | set_flag;

      // register writes take effect at the access edge
      if (access_phase && PWRITE_I && low_lane) begin
         if (hit_control) begin
            next_state.control = PWDATA_I[7:0] & CONTROL_MASK;
         end
         if (hit_enable) begin
            next_state.enable = PWDATA_I[FLAG_W-1:0];
         end
      end

      // read data is captured in the setup cycle
      if (setup_phase) begin
         next_state.read_status = hit_status && !PWRITE_I;
         next_state.prdata      = '0;
         if (!PWRITE_I) begin
            if (hit_status) begin
               // upper nibble stays zero
               next_state.prdata[FLAG_W-1:0] = view_now;
            end
            if (hit_control) begin
               next_state.prdata[7:0] = state.control;
            end
            if (hit_enable) begin
               next_state.prdata[FLAG_W-1:0] = state.enable;
            end
            if (hit_pin) begin
               next_state.prdata[PIN_W-1:0] = pins;
            end
         end
      end else if (access_phase) begin
         next_state.read_status = 1'b0;
      end

      // context bits survive the bus reset while power events are on
      context_reset = host_bus_reset && !power_mgmt_event;
      if (context_reset) begin
         next_state.flag                   = '0;
         next_state.enable                 = ENABLE_RESET;
         next_state.control[CARD_KIND_BIT] = 1'b0;
      end

      view_next = visible(next_state.flag, next_state.enable,
                          next_state.control[CARD_KIND_BIT],
                          next_state.control[RING_ENABLE_BIT],
                          ring_indicate_pin);
      next_state.irq = |view_next;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         state.flag           <= STATUS_RESET[FLAG_W-1:0];
         state.enable         <= ENABLE_RESET;
         state.control        <= CONTROL_RESET;
         // trackers start at the idle levels the synchroniser resets to
         state.cd_first_last  <= PIN_IDLE[PIN_CD_FIRST];
         state.cd_second_last <= PIN_IDLE[PIN_CD_SECOND];
         state.ready_last     <= PIN_IDLE[PIN_READY];
         state.read_status    <= 1'b0;
         state.prdata         <= '0;
         state.irq            <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

endmodule

`default_nettype wire

// file: tb/csc_flags_monitor.sv
/* checker for the card status-change flag block: relations between read data,
   enables, card kind and the interrupt request.
   assumes it is bound to the top module and sees only its ports. */
`default_nettype none
module csc_flags_monitor
   import csc_flags_pkg::*;
(
   input wire logic              CLOCK_I,
   input wire logic              RST_B_I,
   input wire logic              HOST_BUS_RESET_B_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [DATA_W-1:0] PWDATA_I,
   input wire logic [3:0]        PSTRB_I,
   input wire logic [DATA_W-1:0] PRDATA_O,
   input wire logic              PREADY_O,
   input wire logic              PSLVERR_O,
   input wire logic              CARD_DETECT_FIRST_B_I,
   input wire logic              CARD_DETECT_SECOND_B_I,
   input wire logic              CARD_READY_I,
   input wire logic              BATTERY_VOLTAGE_DETECT_PIN_I,
   input wire logic              BATTERY_WARNING_PIN_B_I,
   input wire logic              CARD_STATUS_CHANGE_PIN_B_I,
   input wire logic              CSC_IRQ_O
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // shadows learned from completed writes
   // ----------------------------------------------------------------
   logic              clr_mode, io_kind, ring_on, pme_on, acc, rd_sts, idle;
   logic [FLAG_W-1:0] en_seen;
   assign acc    = PSEL_I && PENABLE_I;
   assign rd_sts = acc && !PWRITE_I && PADDR_I == STATUS_OFFSET;
   assign idle   = BATTERY_WARNING_PIN_B_I && CARD_STATUS_CHANGE_PIN_B_I && !ring_on;
   // enables only accumulate: a stale enable weakens a check, never falsely fires it
   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         {clr_mode, io_kind, ring_on, pme_on, en_seen} <= '0;
      end else if (acc && PWRITE_I && PSTRB_I[0]) begin
         if (PADDR_I == CONTROL_OFFSET) begin
            clr_mode <= PWDATA_I[CLEAR_MODE_BIT];
            io_kind  <= PWDATA_I[CARD_KIND_BIT];
            ring_on  <= PWDATA_I[RING_ENABLE_BIT];
            pme_on   <= PWDATA_I[PME_ENABLE_BIT];
         end
         if (PADDR_I == ENABLE_OFFSET) en_seen <= en_seen | PWDATA_I[FLAG_W-1:0];
      end else if (!HOST_BUS_RESET_B_I && !pme_on) begin
         io_kind <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   reset_quiet_a: assert property (
      $rose(RST_B_I) |-> !CSC_IRQ_O && PRDATA_O == '0) else $error("output not quiet after reset");
   reserved_zero_a: assert property (
      rd_sts |-> PRDATA_O[7:4] == 4'h0) else $error("reserved status bits set");
   upper_zero_a: assert property (
      acc && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0) else $error("upper read bits set");
   disabled_zero_a: assert property (
      rd_sts |-> (PRDATA_O[3:0] & ~en_seen) == 4'h0) else $error("disabled flag reads one");
   io_kind_zero_a: assert property (
      rd_sts && io_kind |-> PRDATA_O[2:1] == 2'b00) else $error("io card shows bits two or one");
   irq_level_a: assert property (
      rd_sts |-> $past(CSC_IRQ_O) == (PRDATA_O[3:0] != 4'h0)) else $error("irq disagrees with flags");
   read_clears_a: assert property (
      rd_sts && !clr_mode && idle |=> !CSC_IRQ_O) else $error("read did not clear flags");
   w1c_keep_a: assert property (
      rd_sts && clr_mode && PRDATA_O[CD_CHANGE_BIT] |=> CSC_IRQ_O) else $error("read cleared in write mode");
   cover property (rd_sts && PRDATA_O[3:0] == 4'hf);
   cover property (rd_sts && io_kind && PRDATA_O[0]);
   cover property ($rose(CSC_IRQ_O));
endmodule
bind card_status_change_flags csc_flags_monitor csc_flags_monitor_i (
   .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .HOST_BUS_RESET_B_I(HOST_BUS_RESET_B_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .CARD_DETECT_FIRST_B_I(CARD_DETECT_FIRST_B_I),
   .CARD_DETECT_SECOND_B_I(CARD_DETECT_SECOND_B_I), .CARD_READY_I(CARD_READY_I),
   .BATTERY_VOLTAGE_DETECT_PIN_I(BATTERY_VOLTAGE_DETECT_PIN_I),
   .BATTERY_WARNING_PIN_B_I(BATTERY_WARNING_PIN_B_I),
   .CARD_STATUS_CHANGE_PIN_B_I(CARD_STATUS_CHANGE_PIN_B_I), .CSC_IRQ_O(CSC_IRQ_O));
`default_nettype wire

// file: tb/card_socket_model.sv
/* model of a 16-bit card seated in the socket: it drives its pins as levels.
   assumes the bench asks for each change; a change lands just after a rising edge. */
`default_nettype none
module card_socket_model
   import csc_flags_pkg::*;
(
   input  wire logic clock_i,
   output logic      [5:0] pins_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // seated card: detects low, ready low, battery and status lines idle high
   logic [5:0] level = 6'h38;
   assign pins_o = level;
   task automatic set_pin(input int idx, input logic v);
      @(posedge clock_i);
      level[idx] <= v;
   endtask
endmodule
`default_nettype wire

// file: tb/card_status_change_flags_tb.sv
/* self-checking bench for the card status-change flags, driven over apb.
   assumes the checker is bound in and the card model drives the socket pins. */
`default_nettype none
module card_status_change_flags_tb
   import csc_flags_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rst_b, bus_rst_b, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0]  pins;
   int          num_errors = 0;
   int          checks_done = 0;
   card_socket_model card_socket_model_i (.clock_i(clock), .pins_o(pins));
   card_status_change_flags card_status_change_flags_i (
      .CLOCK_I(clock), .RST_B_I(rst_b), .HOST_BUS_RESET_B_I(bus_rst_b), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .CARD_DETECT_FIRST_B_I(pins[PIN_CD_FIRST]), .CARD_DETECT_SECOND_B_I(pins[PIN_CD_SECOND]),
      .CARD_READY_I(pins[PIN_READY]), .BATTERY_VOLTAGE_DETECT_PIN_I(pins[PIN_BVD_RING]),
      .BATTERY_WARNING_PIN_B_I(pins[PIN_BATT_WARN]), .CARD_STATUS_CHANGE_PIN_B_I(pins[PIN_STS_CHANGE]),
      .CSC_IRQ_O(irq));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n = 0;
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         num_errors++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] d;
      logic        e;
      apb(1'b1, a, wd, d, e);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask = 32'hffffffff);
      logic [31:0] d;
      logic        e;
      apb(1'b0, a, 32'h0, d, e);
      check(d & mask, exp);
   endtask
   task automatic pin(input int idx, input logic v);
      card_socket_model_i.set_pin(idx, v);
      repeat (6) @(posedge clock);
   endtask
   task automatic irq_is(input logic v);
      repeat (2) @(posedge clock);
      check({31'h0, irq}, {31'h0, v});
   endtask
   task automatic do_reset();
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
   endtask
   task automatic bus_reset();
      @(posedge clock);
      bus_rst_b <= 1'b0;
      repeat (4) @(posedge clock);
      bus_rst_b <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      report_and_stop();
   end
   initial begin
      logic [31:0] d;
      logic        e;
      {rst_b, bus_rst_b, psel, penable, pwrite, paddr, pwdata} = {1'b0, 1'b1, 3'b000, 12'h000, 32'h0};
      do_reset();
      rd_chk(STATUS_OFFSET, 32'h0);
      rd_chk(CONTROL_OFFSET, 32'h0);
      rd_chk(ENABLE_OFFSET, 32'h0);
      rd_chk(PIN_OFFSET, 32'h78);
      apb(1'b0, 12'h900, 32'h0, d, e);
      check({31'h0, e}, 32'h1);
      check(d, 32'h0);
      pin(PIN_CD_FIRST, 1'b1);
      pin(PIN_READY, 1'b1);
      rd_chk(STATUS_OFFSET, 32'h0);
      pin(PIN_READY, 1'b0);
      wr(ENABLE_OFFSET, 32'hf);
      rd_chk(ENABLE_OFFSET, 32'hf);
      pin(PIN_CD_FIRST, 1'b0);
      pin(PIN_READY, 1'b1);
      pin(PIN_BATT_WARN, 1'b0);
      pin(PIN_STS_CHANGE, 1'b0);
      irq_is(1'b1);
      pin(PIN_BATT_WARN, 1'b1);
      pin(PIN_STS_CHANGE, 1'b1);
      rd_chk(STATUS_OFFSET, 32'hf);
      rd_chk(STATUS_OFFSET, 32'h0);
      irq_is(1'b0);
      wr(CONTROL_OFFSET, 32'h4);
      pin(PIN_CD_SECOND, 1'b1);
      rd_chk(STATUS_OFFSET, 32'h8);
      rd_chk(STATUS_OFFSET, 32'h8);
      wr(STATUS_OFFSET, 32'h0);
      rd_chk(STATUS_OFFSET, 32'h8);
      wr(STATUS_OFFSET, 32'h8);
      rd_chk(STATUS_OFFSET, 32'h0);
      wr(CONTROL_OFFSET, 32'h24);
      pin(PIN_READY, 1'b0);
      pin(PIN_READY, 1'b1);
      pin(PIN_BATT_WARN, 1'b0);
      pin(PIN_STS_CHANGE, 1'b0);
      rd_chk(STATUS_OFFSET, 32'h1);
      pin(PIN_BATT_WARN, 1'b1);
      pin(PIN_STS_CHANGE, 1'b1);
      wr(STATUS_OFFSET, 32'hf);
      wr(CONTROL_OFFSET, 32'h84);
      pin(PIN_BVD_RING, 1'b0);
      rd_chk(STATUS_OFFSET, 32'h1, 32'h1);
      pin(PIN_BVD_RING, 1'b1);
      rd_chk(STATUS_OFFSET, 32'h0, 32'h1);
      wr(CONTROL_OFFSET, 32'h4);
      wr(STATUS_OFFSET, 32'hf);
      pin(PIN_CD_FIRST, 1'b1);
      rd_chk(STATUS_OFFSET, 32'h8);
      bus_reset();
      rd_chk(STATUS_OFFSET, 32'h0);
      rd_chk(ENABLE_OFFSET, 32'h0);
      rd_chk(CONTROL_OFFSET, 32'h4);
      wr(CONTROL_OFFSET, 32'h5);
      wr(ENABLE_OFFSET, 32'hf);
      pin(PIN_CD_FIRST, 1'b0);
      bus_reset();
      rd_chk(STATUS_OFFSET, 32'h8);
      rd_chk(ENABLE_OFFSET, 32'hf);
      do_reset();
      rd_chk(STATUS_OFFSET, 32'h0);
      rd_chk(CONTROL_OFFSET, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
